// file: shared/power_mode_pkg.sv
// Constants, register map and encodings for the operating mode and wake-up controller
package power_mode_pkg;
   localparam int          CLK_HZ            = 10_000_000;
   localparam int          POR_DELAY_MS      = 100;
   localparam int          POR_DELAY_CYCLES  = POR_DELAY_MS * (CLK_HZ / 1000);
   localparam int          POR_CNT_W         = 20;
   localparam logic [7:0]  SST_SHORT_TICKS   = 8'h02;
   localparam logic [7:0]  SST_LONG_TICKS    = 8'h80;
   localparam int          INT_COUNT         = 4;

   // Register byte offsets
   localparam logic [3:0]  CONTROL_OFS       = 4'h0;
   localparam logic [3:0]  STATUS_OFS        = 4'h4;
   localparam logic [3:0]  WAKE_ENABLE_OFS   = 4'h8;
   localparam logic [3:0]  WAKE_CAUSE_OFS    = 4'hC;

   // Field positions
   localparam int          CTRL_SLOW_SEL_BIT = 0;
   localparam int          CTRL_LOW_PWR_BIT  = 1;
   localparam int          STAT_PDF_BIT      = 0;
   localparam int          STAT_TO_BIT       = 1;
   localparam int          STAT_MODE_LSB     = 2;
   localparam int          STAT_LXT_BIT      = 5;
   localparam int          CAUSE_RESET_BIT   = 0;
   localparam int          CAUSE_PORT_BIT    = 1;
   localparam int          CAUSE_INT_BIT     = 2;
   localparam int          CAUSE_WDT_BIT     = 3;

   // Reset values
   localparam logic        SLOW_SEL_RST      = 1'b0;
   localparam logic        LOW_PWR_RST       = 1'b0;
   localparam logic [7:0]  WAKE_ENABLE_RST   = 8'h00;
   localparam logic [3:0]  WAKE_CAUSE_RST    = 4'h0;

   // Oscillator configuration option codes
   localparam logic [1:0]  CFG_FAST_XTAL     = 2'h0;
   localparam logic [1:0]  CFG_EXT_RC        = 2'h1;
   localparam logic [1:0]  CFG_FAST_RC       = 2'h2;
   localparam logic [1:0]  CFG_FAST_RC_LXT   = 2'h3;

   // Watchdog clock source option codes
   localparam logic [1:0]  WDT_SRC_SLOW_RC   = 2'h0;
   localparam logic [1:0]  WDT_SRC_LXT       = 2'h1;
   localparam logic [1:0]  WDT_SRC_SYS       = 2'h2;

   // Reported operating mode
   localparam logic [2:0]  MODE_NORMAL       = 3'h0;
   localparam logic [2:0]  MODE_SLOW         = 3'h1;
   localparam logic [2:0]  MODE_IDLE         = 3'h2;
   localparam logic [2:0]  MODE_SLEEP        = 3'h3;
   localparam logic [2:0]  MODE_STARTUP      = 3'h4;

   typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_SLEEP, ST_POR_WAIT, ST_SST_WAIT} pm_state_e;
endpackage

// file: design/operating_mode_ctrl.sv
// Operating mode, halt, wake-up and start-up delay control with Avalon-MM register slave
`timescale 1ns/10ps
module operating_mode_ctrl
   import power_mode_pkg::*;
#(
   parameter int POR_DELAY = POR_DELAY_CYCLES
) (
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic [3:0]           address_i,
   input  wire logic                 read_i,
   input  wire logic                 write_i,
   input  wire logic [31:0]          writedata_i,
   input  wire logic [3:0]           byteenable_i,
   output logic                      waitrequest_o,
   output logic      [31:0]          readdata_o,
   input  wire logic [1:0]           osc_cfg_i,
   input  wire logic [1:0]           wdt_src_i,
   input  wire logic                 halt_i,
   input  wire logic                 clr_wdt_i,
   input  wire logic                 ext_reset_i,
   input  wire logic                 wdt_overflow_i,
   input  wire logic [7:0]           port_a_i,
   input  wire logic [INT_COUNT-1:0] int_req_i,
   input  wire logic                 int_enable_i,
   input  wire logic                 stack_full_i,
   input  wire logic                 sys_clk_tick_i,
   output logic                      fast_rc_run_o,
   output logic                      fast_osc_run_o,
   output logic                      slow_crystal_run_o,
   output logic                      slow_crystal_low_power_o,
   output logic                      sys_clk_slow_o,
   output logic                      cpu_run_o,
   output logic                      hold_state_o,
   output logic [2:0]                mode_o,
   output logic                      wdt_clear_o,
   output logic                      wdt_count_en_o,
   output logic                      full_reset_o,
   output logic                      wdt_reset_o,
   output logic                      int_respond_o
);
   pm_state_e              state;
   pm_state_e              next_state;
   logic [1:0]             osc_cfg;
   logic [1:0]             wdt_src;
   logic                   cfg_taken;
   logic                   sys_clk_slow_select;
   logic                   slow_crystal_low_power;
   logic [7:0]             port_a_wake_enable;
   logic [3:0]             wake_cause;
   logic                   power_down_flag;
   logic                   watchdog_expired_flag;
   logic [7:0]             port_prev;
   logic [INT_COUNT-1:0]   int_prev;
   logic [INT_COUNT-1:0]   int_armed;
   logic [POR_CNT_W-1:0]   por_cnt;
   logic [7:0]             tick_cnt;
   logic                   sst_long;
   logic                   int_service;

   // Bus decode
   wire bus_req     = read_i | write_i;
   wire bus_fire    = bus_req & ~waitrequest_o;
   wire wr_lane0    = write_i & bus_fire & byteenable_i[0];
   wire wr_control  = wr_lane0 & (address_i == CONTROL_OFS);
   wire wr_wake_en  = wr_lane0 & (address_i == WAKE_ENABLE_OFS);

   // Clock configuration
   wire lxt_fitted   = (osc_cfg == CFG_FAST_RC_LXT);
   wire slow_active  = lxt_fitted & sys_clk_slow_select;
   wire crystal_clk  = (osc_cfg == CFG_FAST_XTAL) | slow_active;
   wire rc_fast_cfg  = (osc_cfg == CFG_FAST_RC) | lxt_fitted;
   wire halted       = (state == ST_IDLE) | (state == ST_SLEEP);
   wire running      = (state == ST_RUN);
   wire halt_now     = running & halt_i & ~ext_reset_i;

   // Wake sources
   wire [7:0]           port_fall = port_prev & ~port_a_i & port_a_wake_enable;
   wire [INT_COUNT-1:0] int_rise  = int_req_i & ~int_prev;
   wire port_wake  = |port_fall;
   wire int_wake   = |(int_rise & int_armed);
   wire any_wake   = port_wake | int_wake | wdt_overflow_i;

   // Start-up delay
   wire [7:0] sst_target = sst_long ? SST_LONG_TICKS : SST_SHORT_TICKS;
   wire por_done  = (por_cnt == POR_CNT_W'(POR_DELAY - 1));
   wire sst_done  = sys_clk_tick_i & (tick_cnt == sst_target - 8'h01);

   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (halt_i)
               next_state = lxt_fitted ? ST_IDLE : ST_SLEEP;
         end
         ST_IDLE,
         ST_SLEEP: begin
            if (any_wake)
               next_state = ST_SST_WAIT;
         end
         ST_POR_WAIT: begin
            if (por_done)
               next_state = ST_SST_WAIT;
         end
         ST_SST_WAIT: begin
            if (sst_done)
               next_state = ST_RUN;
         end
         default: next_state = ST_RUN;
      endcase
      if (ext_reset_i)
         next_state = ST_POR_WAIT;
   end

   wire entering_sst = (next_state == ST_SST_WAIT) & (state != ST_SST_WAIT);
   wire leaving_sst  = (state == ST_SST_WAIT) & (next_state == ST_RUN);

   // Mode is registered from the next state so it moves with hold_state_o and cpu_run_o
   wire [2:0] next_mode = (next_state == ST_RUN) ? (slow_active ? MODE_SLOW : MODE_NORMAL) :
                          (next_state == ST_IDLE)  ? MODE_IDLE :
                          (next_state == ST_SLEEP) ? MODE_SLEEP : MODE_STARTUP;

   wire [31:0] rd_mux =
      (address_i == CONTROL_OFS)     ? {30'h0000_0000, slow_crystal_low_power,
                                        sys_clk_slow_select} :
      (address_i == STATUS_OFS)      ? {26'h000_0000, lxt_fitted, mode_o,
                                        watchdog_expired_flag, power_down_flag} :
      (address_i == WAKE_ENABLE_OFS) ? {24'h00_0000, port_a_wake_enable} :
      (address_i == WAKE_CAUSE_OFS)  ? {28'h000_0000, wake_cause} :
                                       32'h0000_0000;

   wire [3:0] next_cause = {wdt_overflow_i, int_wake, port_wake, 1'b0};

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Configuration options are captured once after reset release
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg_taken <= 1'b0;
         osc_cfg   <= CFG_FAST_RC;
         wdt_src   <= WDT_SRC_SLOW_RC;
      end else if (!cfg_taken) begin
         cfg_taken <= 1'b1;
         osc_cfg   <= osc_cfg_i;
         wdt_src   <= wdt_src_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         waitrequest_o <= 1'b1;
         readdata_o    <= 32'h0000_0000;
      end else begin
         waitrequest_o <= ~(bus_req & waitrequest_o);
         if (read_i & waitrequest_o)
            readdata_o <= rd_mux;
      end
   end

   // Software registers; halted CPU cannot write, so they hold while halted, except that ext_reset_i clears sys_clk_slow_select
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sys_clk_slow_select    <= SLOW_SEL_RST;
         slow_crystal_low_power <= LOW_PWR_RST;
         port_a_wake_enable     <= WAKE_ENABLE_RST;
      end else begin
         if (ext_reset_i)
            sys_clk_slow_select <= SLOW_SEL_RST;
         else if (wr_control)
            sys_clk_slow_select <= writedata_i[CTRL_SLOW_SEL_BIT];
         if (wr_control)
            slow_crystal_low_power <= writedata_i[CTRL_LOW_PWR_BIT];
         if (wr_wake_en)
            port_a_wake_enable <= writedata_i[7:0];
      end
   end

   // Status flags: hardware set wins over a clear in the same cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         power_down_flag       <= 1'b0;
         watchdog_expired_flag <= 1'b0;
      end else begin
         if (halt_now)
            power_down_flag <= 1'b1;
         else if (clr_wdt_i)
            power_down_flag <= 1'b0;
         if (wdt_overflow_i)
            watchdog_expired_flag <= 1'b1;
         else if (halt_now)
            watchdog_expired_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         port_prev <= 8'hFF;
         int_prev  <= '0;
         int_armed <= '0;
      end else begin
         port_prev <= port_a_i;
         int_prev  <= int_req_i;
         if (halt_now)
            int_armed <= ~int_req_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         por_cnt    <= '0;
         tick_cnt   <= 8'h00;
         sst_long   <= 1'b1;
         wake_cause <= WAKE_CAUSE_RST;
      end else begin
         por_cnt  <= (state == ST_POR_WAIT && !ext_reset_i) ? por_cnt + 1'b1 : '0;
         if (state != ST_SST_WAIT)
            tick_cnt <= 8'h00;
         else if (sys_clk_tick_i)
            tick_cnt <= tick_cnt + 8'h01;
         if (entering_sst)
            sst_long <= (state == ST_POR_WAIT) | crystal_clk;
         if (ext_reset_i)
            wake_cause <= 4'h1 << CAUSE_RESET_BIT;
         else if (halted && any_wake)
            wake_cause <= next_cause;
      end
   end

   // Interrupt wake: serviced on resume only when enabled with stack room
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         int_service   <= 1'b0;
         int_respond_o <= 1'b0;
      end else begin
         if (ext_reset_i)
            int_service <= 1'b0;
         else if (halted && int_wake)
            int_service <= int_enable_i & ~stack_full_i;
         else if (leaving_sst)
            int_service <= 1'b0;
         int_respond_o <= leaving_sst & int_service;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fast_rc_run_o            <= 1'b1;
         fast_osc_run_o           <= 1'b0;
         slow_crystal_run_o       <= 1'b0;
         slow_crystal_low_power_o <= LOW_PWR_RST;
         sys_clk_slow_o           <= 1'b0;
         cpu_run_o                <= 1'b0;
         hold_state_o             <= 1'b0;
         mode_o                   <= MODE_STARTUP;
         wdt_clear_o              <= 1'b0;
         wdt_count_en_o           <= 1'b0;
         full_reset_o             <= 1'b0;
         wdt_reset_o              <= 1'b0;
      end else begin
         fast_rc_run_o            <= rc_fast_cfg & ~halted & ~slow_active;
         fast_osc_run_o           <= ~rc_fast_cfg & ~halted;
         slow_crystal_run_o       <= lxt_fitted;
         slow_crystal_low_power_o <= slow_crystal_low_power;
         sys_clk_slow_o           <= slow_active;
         cpu_run_o                <= (next_state == ST_RUN);
         hold_state_o             <= (next_state == ST_IDLE) | (next_state == ST_SLEEP);
         mode_o                   <= next_mode;
         wdt_clear_o              <= halt_now | clr_wdt_i | ext_reset_i;
         wdt_count_en_o           <= ~(halted & (wdt_src == WDT_SRC_SYS));
         full_reset_o             <= ext_reset_i;
         wdt_reset_o              <= wdt_overflow_i & ~ext_reset_i;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   halt_to_idle_a: assert property (halt_now && lxt_fitted |=> state == ST_IDLE)
      else $error("halt with slow crystal did not enter idle");
   halt_to_sleep_a: assert property (halt_now && !lxt_fitted |=> state == ST_SLEEP)
      else $error("halt without slow crystal did not enter sleep");
   halt_flags_a: assert property (halt_now && !wdt_overflow_i
                                  |=> power_down_flag && !watchdog_expired_flag)
      else $error("halt did not set power-down and clear time-out");
   pdf_clear_a: assert property (clr_wdt_i && !halt_now |=> !power_down_flag)
      else $error("clear watchdog did not clear power-down flag");
   wdt_stop_a: assert property (halted && wdt_src == WDT_SRC_SYS |=> !wdt_count_en_o)
      else $error("watchdog on system clock still counting while halted");
   slow_rc_off_a: assert property (running && slow_active |=> !fast_rc_run_o && sys_clk_slow_o)
      else $error("fast rc running in slow mode");
   select_valid_a: assert property (!lxt_fitted |=> !sys_clk_slow_o)
      else $error("slow clock selected without slow crystal");
   osc_exclusive_a: assert property (slow_crystal_run_o |-> !fast_osc_run_o)
      else $error("fast external oscillator with slow crystal");
   halt_frozen_a: assert property (halted && !any_wake && !ext_reset_i
                                   |=> !cpu_run_o && hold_state_o)
      else $error("execution not frozen while halted");
   port_wake_a: assert property (halted && port_wake && !ext_reset_i
                                 |=> state == ST_SST_WAIT && wake_cause[CAUSE_PORT_BIT])
      else $error("port falling edge did not wake");
   wdt_wake_a: assert property (halted && wdt_overflow_i && !ext_reset_i
                                |=> wdt_reset_o && watchdog_expired_flag && !full_reset_o)
      else $error("watchdog wake did not give watchdog reset");
   reset_wake_a: assert property (ext_reset_i |=> state == ST_POR_WAIT && full_reset_o)
      else $error("external reset did not start power-on wait");
   stale_int_a: assert property (halted && !port_wake && !wdt_overflow_i && !int_wake
                                 && !ext_reset_i |=> halted)
      else $error("woke without a valid source");
   short_sst_a: assert property (entering_sst && !(state == ST_POR_WAIT) && !crystal_clk
                                 && !ext_reset_i ##1 (sys_clk_tick_i && !ext_reset_i) [*2]
                                 |=> cpu_run_o)
      else $error("rc start-up not two clocks");
   no_early_run_a: assert property ($rose(cpu_run_o) && $past(state) == ST_SST_WAIT
                                    |-> $past(tick_cnt) == sst_target - 8'h01)
      else $error("execution released before start-up count");
   int_respond_a: assert property (int_respond_o |-> cpu_run_o && $past(state) == ST_SST_WAIT)
      else $error("interrupt response outside resume");

   idle_entry_c: cover property (halt_now ##1 state == ST_IDLE);
   port_wake_c: cover property (state == ST_SLEEP && port_wake ##[1:200] cpu_run_o);
   por_resume_c: cover property (state == ST_POR_WAIT ##1 state == ST_SST_WAIT);
   int_respond_c: cover property (int_respond_o);
endmodule // operating_mode_ctrl

// file: bench/operating_mode_and_wakeup_ctrl_tb.sv
// Self-checking bench for the operating mode and wake-up controller
`timescale 1ns/10ps
module operating_mode_and_wakeup_ctrl_tb import power_mode_pkg::*; ;
   logic                 clk_i = 1'h0;
   logic                 sys_rst_i = 1'h1;
   logic [3:0]           address_i = 4'h0;
   logic [3:0]           byteenable_i = 4'hF;
   logic                 read_i = 1'h0, write_i = 1'h0, halt_i = 1'h0, clr_wdt_i = 1'h0;
   logic                 ext_reset_i = 1'h0, wdt_overflow_i = 1'h0, sys_clk_tick_i = 1'h0;
   logic                 int_enable_i = 1'h0, stack_full_i = 1'h0;
   logic [31:0]          writedata_i = 32'h0000_0000;
   logic [31:0]          readdata_o, rd;
   logic [1:0]           osc_cfg_i = CFG_FAST_XTAL;
   logic [1:0]           wdt_src_i = WDT_SRC_SLOW_RC;
   logic [7:0]           port_a_i = 8'hFF;
   logic [INT_COUNT-1:0] int_req_i = '0;
   logic                 waitrequest_o, fast_rc_run_o, fast_osc_run_o, slow_crystal_run_o;
   logic                 slow_crystal_low_power_o, sys_clk_slow_o, cpu_run_o, hold_state_o;
   logic                 wdt_clear_o, wdt_count_en_o, full_reset_o, wdt_reset_o, int_respond_o;
   logic [2:0]           mode_o;
   int                   n_fail = 0, n_compared = 0, n_resp = 0, n_full = 0;

   operating_mode_ctrl #(.POR_DELAY(20)) DUT (.clk_i, .sys_rst_i, .address_i, .read_i, .write_i,
      .writedata_i, .byteenable_i, .waitrequest_o, .readdata_o, .osc_cfg_i, .wdt_src_i, .halt_i,
      .clr_wdt_i, .ext_reset_i, .wdt_overflow_i, .port_a_i, .int_req_i, .int_enable_i,
      .stack_full_i, .sys_clk_tick_i, .fast_rc_run_o, .fast_osc_run_o, .slow_crystal_run_o,
      .slow_crystal_low_power_o, .sys_clk_slow_o, .cpu_run_o, .hold_state_o, .mode_o,
      .wdt_clear_o, .wdt_count_en_o, .full_reset_o, .wdt_reset_o, .int_respond_o);

   always #50 clk_i = ~clk_i;

   // Pulses are counted so that a missing or doubled one shows
   always @(posedge clk_i) begin
      if (int_respond_o === 1'h1) n_resp++;
      if (full_reset_o === 1'h1) n_full++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      read_i <= ~wr;
      write_i <= wr;
      address_i <= a;
      writedata_i <= wd;
      do @(posedge clk_i); while (waitrequest_o !== 1'h0);
      rd = readdata_o;
      read_i <= 1'h0;
      write_i <= 1'h0;
      #1;
   endtask

   // One-cycle pulse: bit0 halt, bit1 clear watchdog, bit2 external reset, bit3 overflow
   task automatic act(input logic [3:0] p);
      @(posedge clk_i);
      {wdt_overflow_i, ext_reset_i, clr_wdt_i, halt_i} <= p;
      @(posedge clk_i);
      {wdt_overflow_i, ext_reset_i, clr_wdt_i, halt_i} <= 4'h0;
      #1;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_i);
         sys_clk_tick_i <= 1'h1;
         @(posedge clk_i);
         sys_clk_tick_i <= 1'h0;
      end
      #1;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic rst(input logic [1:0] cfg, input logic [1:0] ws);
      @(posedge clk_i);
      sys_rst_i <= 1'h1;
      osc_cfg_i <= cfg;
      wdt_src_i <= ws;
      cyc(5);
      sys_rst_i <= 1'h0;
      cyc(1);
   endtask

   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      n_fail++;
      results;
   end

   initial begin
      rst(CFG_FAST_XTAL, WDT_SRC_SLOW_RC);
      chk(cpu_run_o, 1'h1, "no run");
      bus(1'h1, CONTROL_OFS, 32'h0000_0001);
      chk(sys_clk_slow_o, 1'h0, "select acted");
      chk(slow_crystal_run_o, 1'h0, "slow xtal on");
      chk(fast_osc_run_o, 1'h1, "fast osc off");
      bus(1'h0, 4'h1, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped");
      act(4'h1);
      chk(mode_o, MODE_SLEEP, "no sleep");
      chk(hold_state_o, 1'h1, "no hold");
      act(4'h4);
      chk(mode_o, MODE_STARTUP, "no startup");
      cyc(1);
      chk(n_full, 1, "full reset");
      cyc(25);
      ticks(127);
      chk(cpu_run_o, 1'h0, "early run");
      ticks(1);
      chk(cpu_run_o, 1'h1, "late run");
      $display("test crystal done");

      rst(CFG_FAST_RC, WDT_SRC_SLOW_RC);
      bus(1'h0, CONTROL_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "control reset");
      bus(1'h0, WAKE_ENABLE_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "enable reset");
      bus(1'h1, WAKE_ENABLE_OFS, 32'h0000_0001);
      act(4'h1);
      chk(wdt_clear_o, 1'h1, "no wdt clear");
      chk(wdt_count_en_o, 1'h1, "wdt stopped");
      @(posedge clk_i) port_a_i <= 8'hFD;
      cyc(3);
      chk(mode_o, MODE_SLEEP, "masked pin woke");
      @(posedge clk_i) port_a_i <= 8'hFC;
      cyc(2);
      chk(mode_o, MODE_STARTUP, "pin no wake");
      ticks(1);
      chk(cpu_run_o, 1'h0, "early run");
      ticks(1);
      chk(cpu_run_o, 1'h1, "late run");
      chk(mode_o, MODE_NORMAL, "not normal");
      bus(1'h0, WAKE_CAUSE_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0002, "cause");
      bus(1'h0, STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0001, "status halt");
      act(4'h2);
      bus(1'h0, STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "pdf kept");
      @(posedge clk_i) int_req_i <= 4'h1;
      int_enable_i <= 1'h1;
      act(4'h1);
      @(posedge clk_i) int_req_i <= 4'h0;
      @(posedge clk_i) int_req_i <= 4'h1;
      cyc(3);
      chk(mode_o, MODE_SLEEP, "stale int woke");
      @(posedge clk_i) int_req_i <= 4'h5;
      cyc(2);
      chk(mode_o, MODE_STARTUP, "int no wake");
      ticks(2);
      cyc(1);
      chk(n_resp, 1, "no response");
      @(posedge clk_i) int_req_i <= 4'h0;
      stack_full_i <= 1'h1;
      act(4'h1);
      @(posedge clk_i) int_req_i <= 4'h2;
      cyc(2);
      ticks(2);
      cyc(1);
      chk(cpu_run_o, 1'h1, "stack full no run");
      chk(n_resp, 1, "full stack response");
      $display("test rc done");

      rst(CFG_FAST_RC_LXT, WDT_SRC_SYS);
      bus(1'h1, CONTROL_OFS, 32'h0000_0003);
      cyc(1);
      chk(sys_clk_slow_o, 1'h1, "no slow clock");
      chk(fast_rc_run_o, 1'h0, "fast rc runs");
      chk(slow_crystal_low_power_o, 1'h1, "low power");
      chk(mode_o, MODE_SLOW, "not slow");
      bus(1'h0, STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0024, "status slow");
      act(4'h1);
      chk(mode_o, MODE_IDLE, "not idle");
      chk(slow_crystal_run_o, 1'h1, "xtal stopped");
      cyc(1);
      chk(wdt_count_en_o, 1'h0, "wdt counts");
      act(4'h8);
      chk(mode_o, MODE_STARTUP, "wdt no wake");
      chk(wdt_reset_o, 1'h1, "no wdt reset");
      ticks(127);
      chk(cpu_run_o, 1'h0, "early run");
      ticks(1);
      chk(cpu_run_o, 1'h1, "late run");
      bus(1'h0, STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0027, "status wdt");
      $display("test slow crystal done");
      results;
   end
endmodule // operating_mode_and_wakeup_ctrl_tb
